// ---- include/psp_regs.vh ----
`ifndef PSP_REGS_VH
`define PSP_REGS_VH
// APB byte addresses (one word each)
`define PSP_OFF_LEVELS    12'h000
`define PSP_OFF_LATCH     12'h004
`define PSP_OFF_STATUS    12'h008
`define PSP_OFF_ANCFG     12'h00C
`define PSP_OFF_DATA      12'h010
`define PSP_OFF_DATADIR   12'h014
`define PSP_OFF_EVENT     12'h018
// Status register fields
`define PSP_BIT_INPEND    7
`define PSP_BIT_OUTPEND   6
`define PSP_BIT_OVERRUN   5
`define PSP_BIT_ENABLE    4
// Reset values
`define PSP_RST_STATUS    8'h07
`define PSP_RST_DIR       3'h7
`define PSP_RST_ANCFG     4'h0
`define PSP_RST_DATADIR   8'hFF
// Lowest analog config value that leaves the strobe pins digital
`define PSP_ANCFG_DIGITAL 4'hA
`endif

// ---- logic/psp_sync2.v ----
`timescale 1ns/10ps
module psp_sync2 #(
  parameter WIDTH = 3
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b1}};
      syncOut    <= {WIDTH{1'b1}};
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule

// ---- logic/psp_port.v ----
`timescale 1ns/10ps
`include "psp_regs.vh"

// Notes on behaviour
// - Strobe pins settable; analog pins read zero
// - Direction one floats driver, zero drives latch
// - Direction bits govern drivers even when analog
// - Reset makes strobe pins analog inputs
// - Output latch readable; reads latch not pins
// - Analog disables input path, not output drive
// - Status bit3 zero; directions reset one
// - Overrun on host write over unread word
// - Slave mode needs enable and no multi-PWM
// - Pin0 read, pin1 write, pin2 select
// - Software sets inputs and digital config
// - Host write spans select and write low
// - Write end sets event and input-pending
// - Host read drives data latch onto pins
// - Host read clears output-pending flag
// - CPU write during read shows, no flag
// - Read end floats data pins, sets event
module psp_port (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  strobePinIn,
  output reg  [2:0]  strobePinOut,
  output reg  [2:0]  strobePinOe,
  input  wire [7:0]  dataPinIn,
  output reg  [7:0]  dataPinOut,
  output reg  [7:0]  dataPinOe,
  input  wire        pwmMultiOutput,
  output reg         slaveInterfaceEventFlag
);
  reg  [2:0] stLatch_reg;
  reg  [2:0] stDir_reg;
  reg        inPend_reg;
  reg        outPend_reg;
  reg        overrun_reg;
  reg        pspEnable_reg;
  reg  [3:0] anCfg_reg;
  reg  [7:0] dataLatch_reg;
  reg  [7:0] dataIn_reg;
  reg  [7:0] dataDir_reg;
  reg        event_reg;
  reg        wrActive_reg;
  reg        rdActive_reg;
  reg  [7:0] capture_reg;
  wire [2:0] stSync;
  wire [7:0] dataSync;

  psp_sync2 #(.WIDTH(3)) uStrobeSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (strobePinIn),
    .syncOut (stSync)
  );

  psp_sync2 #(.WIDTH(8)) uDataSync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (dataPinIn),
    .syncOut (dataSync)
  );

  // Analog selection of a strobe pin: config values below the digital
  // threshold keep channels 5..7 analog in this simplified map.
  wire analogSel = (anCfg_reg < `PSP_ANCFG_DIGITAL);
  wire [2:0] stDigitalIn = analogSel ? 3'h0 : stSync;
  wire slaveOn = pspEnable_reg && !pwmMultiOutput;
  // Strobes only seen through the digital path, so an analog setup blocks them
  wire rdLow = slaveOn && !analogSel && !stSync[0] && !stSync[2];
  wire wrLow = slaveOn && !analogSel && !stSync[1] && !stSync[2];

  wire setup  = psel && !penable;
  wire access = psel && penable;
  wire wrEn   = access && pwrite;
  wire wrLatchData = wrEn && (paddr == `PSP_OFF_DATA);
  wire wrStatus    = wrEn && (paddr == `PSP_OFF_STATUS);
  wire wrEnd = wrActive_reg && !wrLow;
  wire rdEnd = rdActive_reg && !rdLow;

  function known;
    input [11:0] a;
    begin
      known = (a == `PSP_OFF_LEVELS) || (a == `PSP_OFF_LATCH) ||
              (a == `PSP_OFF_STATUS) || (a == `PSP_OFF_ANCFG) ||
              (a == `PSP_OFF_DATA) || (a == `PSP_OFF_DATADIR) ||
              (a == `PSP_OFF_EVENT);
    end
  endfunction

  wire [7:0] statusVal = {inPend_reg, outPend_reg, overrun_reg, pspEnable_reg,
                          1'b0, stDir_reg};

  // Host strobe tracking and flags
  always @(posedge clk_sys) begin
    if (rst) begin
      wrActive_reg <= 1'b0;
      rdActive_reg <= 1'b0;
      capture_reg  <= 8'h00;
    end else begin
      wrActive_reg <= wrLow;
      rdActive_reg <= rdLow;
      if (wrLow)
        capture_reg <= dataSync;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      stLatch_reg   <= 3'h0;
      stDir_reg     <= `PSP_RST_DIR;
      inPend_reg    <= 1'b0;
      outPend_reg   <= 1'b0;
      overrun_reg   <= 1'b0;
      pspEnable_reg <= 1'b0;
      anCfg_reg     <= `PSP_RST_ANCFG;
      dataLatch_reg <= 8'h00;
      dataIn_reg    <= 8'h00;
      dataDir_reg   <= `PSP_RST_DATADIR;
      event_reg     <= 1'b0;
    end else begin
      if (wrEn && paddr == `PSP_OFF_LATCH)
        stLatch_reg <= pwdata[2:0];
      if (wrEn && paddr == `PSP_OFF_LEVELS)
        stLatch_reg <= pwdata[2:0];
      if (wrEn && paddr == `PSP_OFF_ANCFG)
        anCfg_reg <= pwdata[3:0];
      if (wrEn && paddr == `PSP_OFF_DATADIR)
        dataDir_reg <= pwdata[7:0];
      if (wrStatus) begin
        stDir_reg     <= pwdata[2:0];
        pspEnable_reg <= pwdata[`PSP_BIT_ENABLE];
      end
      if (wrLatchData)
        dataLatch_reg <= pwdata[7:0];
      // Output word pending: CPU write sets it unless a host read is running
      if (rdLow)
        outPend_reg <= 1'b0;
      else if (wrLatchData)
        outPend_reg <= 1'b1;
      // Input word pending: set wins over the CPU reading the data port
      if (wrEnd) begin
        inPend_reg <= 1'b1;
        dataIn_reg <= capture_reg;
      end else if (access && !pwrite && paddr == `PSP_OFF_DATA)
        inPend_reg <= 1'b0;
      // Overrun sticks until software writes zero; hardware set wins
      if (wrEnd && inPend_reg)
        overrun_reg <= 1'b1;
      else if (wrStatus && !pwdata[`PSP_BIT_OVERRUN])
        overrun_reg <= 1'b0;
      if (wrEnd || rdEnd)
        event_reg <= 1'b1;
      else if (wrEn && paddr == `PSP_OFF_EVENT && pwdata[0])
        event_reg <= 1'b0;
    end
  end

  // Pin drivers
  always @(posedge clk_sys) begin
    if (rst) begin
      strobePinOut <= 3'h0;
      strobePinOe  <= 3'h0;
      dataPinOut   <= 8'h00;
      dataPinOe    <= 8'h00;
      slaveInterfaceEventFlag <= 1'b0;
    end else begin
      strobePinOut <= stLatch_reg;
      strobePinOe  <= ~stDir_reg;
      // New latch data goes out the same cycle it is written during a read
      dataPinOut   <= wrLatchData ? pwdata[7:0] : dataLatch_reg;
      if (slaveOn)
        dataPinOe <= rdLow ? 8'hFF : 8'h00;
      else
        dataPinOe <= ~dataDir_reg;
      slaveInterfaceEventFlag <= event_reg;
    end
  end

  // APB: zero-wait answer in the access phase
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !known(paddr);
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          `PSP_OFF_LEVELS:  prdata <= {29'h0, stDigitalIn};
          `PSP_OFF_LATCH:   prdata <= {29'h0, stLatch_reg};
          `PSP_OFF_STATUS:  prdata <= {24'h0, statusVal};
          `PSP_OFF_ANCFG:   prdata <= {28'h0, anCfg_reg};
          `PSP_OFF_DATA:    prdata <= {24'h0, slaveOn ? dataIn_reg : dataSync};
          `PSP_OFF_DATADIR: prdata <= {24'h0, dataDir_reg};
          `PSP_OFF_EVENT:   prdata <= {31'h0, event_reg};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- bench/psp_host_model.sv ----
`timescale 1ns/10ps
module psp_host_model (
  input  wire       clk_sys,
  output wire [2:0] strobePinIn,
  input  wire [2:0] strobePinOut,
  input  wire [2:0] strobePinOe,
  output wire [7:0] dataPinIn,
  input  wire [7:0] dataPinOut,
  input  wire [7:0] dataPinOe
);
  reg [2:0] hs = 3'h7;
  reg [7:0] hd = 8'h00;
  reg       hOe = 1'h0;
  reg [7:0] lastLvl = 8'h00;
  assign strobePinIn = strobePinOe & strobePinOut | ~strobePinOe & hs;
  // Released data lines toggle so a stale byte never passes for a driven one
  assign dataPinIn = dataPinOe & dataPinOut | ~dataPinOe & (hOe ? hd : ~lastLvl);
  always @(posedge clk_sys) lastLvl <= dataPinIn;
  // Six cycles per phase, three times what the strobe synchroniser needs
  task automatic step(input [2:0] s, input [7:0] d, input bit oe);
    hs <= s;
    hd <= d;
    hOe <= oe;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ---- bench/psp_port_props.sv ----
`timescale 1ns/10ps
module psp_port_props (
  input wire        clk_sys,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [2:0]  strobePinIn,
  input wire [2:0]  strobePinOut,
  input wire        slaveInterfaceEventFlag
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = psel && penable && pready;
  wire wr = psel && pwrite;
  wire clr = acc && pwrite && paddr == 12'h018;
  wire ev = slaveInterfaceEventFlag;
  wire idle = strobePinIn[2] || &strobePinIn[1:0];
  answer_time_a: assert property (psel && !penable |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  unmapped_err_a: assert property (acc && !pwrite && paddr > 12'h018 |-> pslverr && !prdata)
    else $error("unmapped read");
  mapped_ok_a: assert property (acc && paddr < 12'h01C && !paddr[1:0] |-> !pslverr)
    else $error("mapped refused");
  status_zero_a: assert property (
    acc && !pwrite && paddr == 12'h008 |-> !(prdata & 32'hFFFF_FF08)) else $error("status bits");
  event_hold_a: assert property (
    ev && !clr && !$past(clr) |=> ev) else $error("event lost");
  event_cause_a: assert property (
    $rose(ev) |-> $past(idle, 3)) else $error("event without strobe end");
  latch_cause_a: assert property (
    !$stable(strobePinOut) |-> $past(wr) || $past(wr, 2)) else $error("latch moved");
  cover property ($rose(ev));
  cover property (acc && pslverr);
  cover property (strobePinIn == 3'h2);
endmodule
bind psp_port psp_port_props u_props (.*);

// ---- bench/psp_port_test.sv ----
`timescale 1ns/10ps
`include "psp_regs.vh"
module psp_port_test;
  reg clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg pwmMultiOutput = 1'h0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, r;
  reg errSeen = 1'h0;
  wire [31:0] prdata;
  wire pready, pslverr, slaveInterfaceEventFlag;
  wire [2:0] strobePinIn, strobePinOut, strobePinOe;
  wire [7:0] dataPinIn, dataPinOut, dataPinOe;
  int fails = 0, n_checks = 0;
  always #2 clk_sys = ~clk_sys;
  psp_port dut (.*);
  psp_host_model host (.*);
  task automatic apb(input bit w, input [11:0] a, input [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    r = prdata;
    errSeen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string n, input [31:0] e, g);
    n_checks++;
    fails += (g !== e);
    if (g !== e) $display("mismatch %s expected %h seen %h", n, e, g);
  endtask
  task automatic rd(input string n, input [11:0] a, input [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic st(input [31:0] e);
    rd("status", `PSP_OFF_STATUS, e);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    st(32'h7);
    apb(1'h1, `PSP_OFF_LATCH, 32'h5);
    apb(1'h1, `PSP_OFF_STATUS, 32'h2);
    rd("latch", `PSP_OFF_LATCH, 32'h5);
    chk("pslverr", 32'h0, 32'(errSeen));
    chk("strobeOe", 32'h5, 32'(strobePinOe));
    rd("levels", `PSP_OFF_LEVELS, 32'h0);
    apb(1'h1, `PSP_OFF_LATCH, 32'h0);
    apb(1'h1, `PSP_OFF_ANCFG, 32'hA);
    rd("levels", `PSP_OFF_LEVELS, 32'h2);
    // Strobe pins back to input before enabling, else the driven lows look like a host read
    apb(1'h1, `PSP_OFF_STATUS, 32'h7);
    apb(1'h1, `PSP_OFF_STATUS, 32'h17);
    chk("event", 32'h0, 32'(slaveInterfaceEventFlag));
    for (int i = 0; i < 2; i++) begin
      host.step(3'h1, 8'hA5 - i[7:0], 1'h1);
      host.step(3'h7, 8'hA5 - i[7:0], 1'h1);
    end
    chk("event", 32'h1, 32'(slaveInterfaceEventFlag));
    st(32'hB7);
    rd("data", `PSP_OFF_DATA, 32'hA4);
    apb(1'h1, `PSP_OFF_STATUS, 32'h17);
    apb(1'h1, `PSP_OFF_EVENT, 32'h1);
    st(32'h17);
    apb(1'h1, `PSP_OFF_DATA, 32'h5A);
    st(32'h57);
    host.step(3'h2, 8'h00, 1'h0);
    chk("dataOe", 32'hFF, 32'(dataPinOe));
    chk("dataPins", 32'h5A, 32'(dataPinIn));
    apb(1'h1, `PSP_OFF_DATA, 32'hC3);
    st(32'h17);
    chk("dataPins", 32'hC3, 32'(dataPinIn));
    host.step(3'h7, 8'h00, 1'h0);
    chk("dataOe", 32'h0, 32'(dataPinOe));
    chk("event", 32'h1, 32'(slaveInterfaceEventFlag));
    apb(1'h1, `PSP_OFF_EVENT, 32'h1);
    pwmMultiOutput <= 1'h1;
    host.step(3'h1, 8'h11, 1'h1);
    host.step(3'h7, 8'h11, 1'h1);
    st(32'h17);
    chk("event", 32'h0, 32'(slaveInterfaceEventFlag));
    rd("unmapped", 12'h01C, 32'h0);
    chk("pslverr", 32'h1, 32'(errSeen));
    apb(1'h1, `PSP_OFF_DATADIR, 32'hF);
    @(posedge clk_sys);
    chk("dataOe", 32'hF0, 32'(dataPinOe));
    test_done;
  end
endmodule
